//--- bench/pdes_host_model.sv
// Host two-wire master: drives SCL, pulls SDA low or releases it.
// Assumes the bench resolves SDA with a pull-up into sda_w.
`timescale 1ns/1ps
module pdes_host_model (
    // Clock
    input wire logic clk,
    // Wire
    input wire logic sda_w,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // SDA moves mid low phase only, sampled mid high
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_pull = !b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_w;
        tick(4);
        scl = 1'b0;
    endtask : bit_io
    task automatic start_c();
        tick(4);
        sda_pull = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start_c
    // SCL left high after stop: idle bus stands still
    task automatic stop_c();
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(170);
    endtask : stop_c
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : byte_wr
    task automatic byte_rd(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask : byte_rd
endmodule : pdes_host_model

//--- bench/pdes_slave_checker.sv
// Pin checker for the two-wire presence-detect slave.
// Assumes bind to pdes_slave; SCL and SDA are raw pin levels.
`timescale 1ns/1ps
module pdes_slave_checker #(
    parameter int PROG_CYCLES = 50
)(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Straps and status
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic write_control_input,
    input wire logic busy
);
    int busy_n_q;
    int busy_n_d;
    always_comb begin
        busy_n_d = busy_n_q;
        if (!busy) begin
            busy_n_d = 0;
        end else if (ce) begin
            busy_n_d = busy_n_q + 1;
        end
    end
    always_ff @(posedge clk) begin
        busy_n_q <= busy_n_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rst;
        disable iff (1'b0) !resetn && ce |=> !sda_oe && !busy;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    property p_drive_low;
        sda_oe |-> sda_out == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda driven high");
    property p_oe_scl_low;
        $rose(sda_oe) || $fell(sda_oe) |-> !scl_in;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
    property p_ack_time;
        $rose(sda_oe) |-> $past(scl_in, 5) && !$past(scl_in, 2);
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("drive not after scl fall");
    property p_busy_len;
        $fell(busy) |-> busy_n_q >= PROG_CYCLES - 1 && busy_n_q <= PROG_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("program cycle length");
    property p_busy_quiet;
        busy && $past(busy) |-> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("acked while busy");
    property p_busy_stop;
        $rose(busy) |-> scl_in && sda_in;
    endproperty
    a_busy_stop: assert property (p_busy_stop) else $error("busy not after stop");
    property p_freeze;
        !ce |=> $stable(sda_oe) && $stable(busy);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");
    c_busy: cover property ($rose(busy));
    c_ack: cover property ($rose(sda_oe));
    c_wc: cover property (write_control_input && !scl_in);
endmodule : pdes_slave_checker
bind pdes_slave pdes_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) pdes_slave_checker_i (
    .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr_bit0(strap_addr_bit0),
    .strap_addr_bit1(strap_addr_bit1), .strap_addr_bit2(strap_addr_bit2),
    .write_control_input(write_control_input), .busy(busy));

//--- bench/pdes_slave_test.sv
// Self-checking bench for the two-wire presence-detect slave.
// Assumes host model and checker are compiled before this file.
`timescale 1ns/1ps
`include "pdes_defines.svh"
module pdes_slave_test;
    // Short program cycle keeps the run brief
    localparam int PROG = 400;
    localparam logic [3:0] ARR = `PDES_CODE_ARRAY;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic wc = 1'b0;
    logic [2:0] strap = 3'b101;
    logic scl;
    logic m_pull;
    logic s_out;
    logic s_oe;
    logic busy;
    logic sda_w;
    logic ack;
    logic [7:0] got [32];
    logic [7:0] fix [23] = '{8'h80, 8'h08, 8'h07, 8'h0D, 8'h0B, 8'h01, 8'h48, 8'h00,
        8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hC0};
    bit [22:0] known = 23'h42A1FF;
    int n_fail = 0;
    int checks = 0;
    assign sda_w = s_oe ? s_out : !m_pull;
    initial begin
        forever #4 clk = ~clk;
    end
    pdes_slave #(.PROG_CYCLES(PROG), .LARGE_ROW(1'b1), .LARGE_COL(1'b0)) pdes_slave_i (
        .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda_w),
        .sda_out(s_out), .sda_oe(s_oe), .strap_addr_bit0(strap[0]),
        .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .write_control_input(wc), .busy(busy));
    pdes_host_model pdes_host_model_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_pull(m_pull));
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic send(input logic [7:0] b, input logic exp);
        pdes_host_model_i.byte_wr(b, ack);
        chk("ack", {7'h00, ack}, {7'h00, exp});
    endtask : send
    task automatic wr(input logic [3:0] c, input logic [7:0] a, input logic [7:0] d[$],
        input logic dack);
        pdes_host_model_i.start_c();
        send({c, strap, 1'b0}, 1'b1);
        send(a, 1'b1);
        foreach (d[i]) send(d[i], dack);
        pdes_host_model_i.stop_c();
    endtask : wr
    task automatic rd(input logic [3:0] c, input logic [7:0] a, input int n);
        pdes_host_model_i.start_c();
        send({c, strap, 1'b0}, 1'b1);
        send(a, 1'b1);
        pdes_host_model_i.start_c();
        send({c, strap, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) pdes_host_model_i.byte_rd(i < n - 1, got[i]);
        pdes_host_model_i.stop_c();
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_idle
    initial begin
        repeat (100000) @(negedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        rd(ARR, 8'h00, 23);
        for (int i = 0; i < 23; i++) if (known[i]) chk("fixed", got[i], fix[i]);
        wr(ARR, 8'h20, '{8'h5A}, 1'b1);
        chk("busy", {7'h00, busy}, 8'h01);
        pdes_host_model_i.start_c();
        send({ARR, strap, 1'b0}, 1'b0);
        pdes_host_model_i.stop_c();
        wait_idle();
        rd(ARR, 8'h20, 1);
        chk("byte write", got[0], 8'h5A);
        wc = 1'b1;
        wr(ARR, 8'h20, '{8'hC3}, 1'b0);
        wait_idle();
        rd(ARR, 8'h20, 1);
        chk("blocked write", got[0], 8'h5A);
        wc = 1'b0;
        wr(ARR, 8'h3E, '{8'h11, 8'h22, 8'h33}, 1'b1);
        wait_idle();
        rd(ARR, 8'h3E, 1);
        chk("page", got[0], 8'h11);
        pdes_host_model_i.start_c();
        send({ARR, strap, 1'b1}, 1'b1);
        pdes_host_model_i.byte_rd(1'b0, got[0]);
        pdes_host_model_i.stop_c();
        chk("current", got[0], 8'h22);
        rd(ARR, 8'h30, 1);
        chk("page wrap", got[0], 8'h33);
        for (int k = 0; k < 2; k++) begin
            pdes_host_model_i.start_c();
            send(k == 0 ? {ARR, ~strap, 1'b0} : {4'hB, strap, 1'b0}, 1'b0);
            pdes_host_model_i.stop_c();
        end
        wr(`PDES_CODE_PROT, 8'h00, '{8'hA5}, 1'b1);
        wait_idle();
        rd(`PDES_CODE_PROT, 8'h00, 1);
        chk("protection", got[0], 8'hA5);
        print_verdict();
    end
endmodule : pdes_slave_test

//--- core/pdes_defines.svh
// Constants for the presence-detect two-wire slave.
// Included by the package and the test bench.
`ifndef PDES_DEFINES_SVH
`define PDES_DEFINES_SVH
`define PDES_CODE_ARRAY 4'hA
`define PDES_CODE_PROT 4'h6
`define PDES_PAGE_BITS 4
`define PDES_PROG_TIME_MS 10
`define PDES_CLK_MHZ 125
`define PDES_PROG_CYCLES (`PDES_PROG_TIME_MS * `PDES_CLK_MHZ * 1000)
`define PDES_BUF_TIME_NS 1300
`define PDES_B0_USED 8'h80
`define PDES_B1_TOTAL 8'h08
`define PDES_B2_TYPE 8'h07
`define PDES_B3_ROW_SMALL 8'h0C
`define PDES_B3_ROW_LARGE 8'h0D
`define PDES_B4_COL_SMALL 8'h0B
`define PDES_B4_COL_LARGE 8'h0C
`define PDES_B5_RANKS 8'h01
`define PDES_B6_WIDTH_LO 8'h48
`define PDES_B7_WIDTH_HI 8'h00
`define PDES_B8_LEVELS 8'h04
`define PDES_B13_DEV_WIDTH 8'h04
`define PDES_B15_CCD 8'h01
`define PDES_B17_BANKS 8'h04
`define PDES_B22_ATTR 8'hC0
`endif

//--- core/pdes_line_sync.sv
// Samples SCL and SDA into the clk domain and finds edges and conditions.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module pdes_line_sync
    import pdes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins
    input wire logic scl_in,
    input wire logic sda_in,
    // Events
    output pdes_bus_ev_t ev
);
    logic [1:0] scl_s1_q, scl_s1_d;
    logic [1:0] sync2_q, sync2_d;
    logic [1:0] prev_q, prev_d;

    always_comb begin
        scl_s1_d = {scl_in, sda_in};
        sync2_d = scl_s1_q;
        prev_d = sync2_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_s1_q <= 2'h3;
            sync2_q <= 2'h3;
            prev_q <= 2'h3;
        end else if (ce) begin
            scl_s1_q <= scl_s1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

    // Conditions only with SCL high on both samples
    always_comb begin
        ev.sda = sync2_q[0];
        ev.rise = sync2_q[1] & ~prev_q[1];
        ev.fall = ~sync2_q[1] & prev_q[1];
        ev.start = sync2_q[1] & prev_q[1] & prev_q[0] & ~sync2_q[0];
        ev.stop = sync2_q[1] & prev_q[1] & ~prev_q[0] & sync2_q[0];
    end
endmodule : pdes_line_sync

//--- core/pdes_pkg.sv
// Types for the presence-detect two-wire slave.
// Assumes pdes_defines.svh is on the include path.
`include "pdes_defines.svh"
package pdes_pkg;
    typedef enum logic [5:0] {
        PDES_IDLE = 6'h01,
        PDES_SEL = 6'h02,
        PDES_ACK = 6'h04,
        PDES_WADDR = 6'h08,
        PDES_WDATA = 6'h10,
        PDES_READ = 6'h20
    } pdes_state_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } pdes_bus_ev_t;
    typedef struct packed {
        logic we;
        logic prot;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdes_mem_req_t;
endpackage : pdes_pkg

//--- core/pdes_slave.sv
// Presence-detect two-wire slave: select decode, reads, writes, busy.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain.
`timescale 1ns/1ps
module pdes_slave
    import pdes_pkg::*;
#(
    parameter int PROG_CYCLES = `PDES_PROG_CYCLES,
    parameter bit LARGE_ROW = 1'b0,
    parameter bit LARGE_COL = 1'b0
)(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and write control
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic write_control_input,
    // Status
    output logic busy
);
    pdes_bus_ev_t ev;
    pdes_mem_req_t req;
    pdes_state_t state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] addr_q, addr_d;
    logic prot_q, prot_d;
    logic rd_q, rd_d;
    logic wrote_q, wrote_d;
    logic oe_q, oe_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic [23:0] prog_q, prog_d;
    logic [1:0] strap_s1_q, strap_s2_q;
    logic [2:0] st1_q, st2_q;
    logic [7:0] rdata;
    logic [2:0] straps;
    logic sel_match;
    logic [7:0] next_byte;

    pdes_line_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    pdes_store #(
        .LARGE_ROW(LARGE_ROW),
        .LARGE_COL(LARGE_COL)
    ) u_store (
        .clk(clk),
        .ce(ce),
        .req(req),
        .rdata(rdata)
    );

    // Straps and write control come from pins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st1_q <= 3'h0;
            st2_q <= 3'h0;
            strap_s1_q <= 2'h3;
            strap_s2_q <= 2'h3;
        end else if (ce) begin
            st1_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            st2_q <= st1_q;
            strap_s1_q <= {write_control_input, 1'b1};
            strap_s2_q <= strap_s1_q;
        end
    end
    assign straps = st2_q;

    assign next_byte = {shift_q[6:0], ev.sda};
    // Whole select byte already sits in shift_q at the eighth falling edge
    assign sel_match = (shift_q[3:1] == straps) &&
        (shift_q[7:4] == `PDES_CODE_ARRAY || shift_q[7:4] == `PDES_CODE_PROT);

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_d = bit_q;
        addr_d = addr_q;
        prot_d = prot_q;
        rd_d = rd_q;
        wrote_d = wrote_q;
        oe_d = oe_q;
        rbyte_d = rbyte_q;
        prog_d = prog_q;
        req = '0;
        req.addr = addr_q;
        req.prot = prot_q;
        req.wdata = next_byte;
        if (prog_q != 24'h0) begin
            // Bus ignored while programming
            prog_d = prog_q - 24'h1;
            state_d = PDES_IDLE;
            oe_d = 1'b0;
        end else if (ev.stop) begin
            state_d = PDES_IDLE;
            oe_d = 1'b0;
            if (wrote_q) begin
                prog_d = 24'(PROG_CYCLES);
            end
            wrote_d = 1'b0;
        end else if (ev.start) begin
            // Restart keeps the address just supplied
            state_d = PDES_SEL;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (ev.rise) begin
            case (state_q)
                PDES_SEL, PDES_WADDR, PDES_WDATA: begin
                    // Ack clock must not shift or count
                    if (bit_q < 4'h8) begin
                        shift_d = next_byte;
                        bit_d = bit_q + 4'h1;
                    end
                end
                PDES_READ: begin
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h8 && ev.sda) begin
                        state_d = PDES_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (ev.fall) begin
            case (state_q)
                PDES_SEL: begin
                    if (bit_q == 4'h8) begin
                        if (sel_match) begin
                            prot_d = (shift_q[7:4] == `PDES_CODE_PROT);
                            rd_d = shift_q[0];
                            oe_d = 1'b1;
                            state_d = PDES_ACK;
                        end else begin
                            state_d = PDES_IDLE;
                        end
                    end
                end
                PDES_ACK: begin
                    oe_d = 1'b0;
                    bit_d = 4'h0;
                    if (rd_q) begin
                        state_d = PDES_READ;
                        oe_d = ~rdata[7];
                        rbyte_d = {rdata[6:0], 1'b0};
                        addr_d = addr_q + 8'h1;
                    end else if (bit_q == 4'h9) begin
                        // Word address already taken: data follows
                        state_d = PDES_WDATA;
                    end else begin
                        state_d = PDES_WADDR;
                    end
                end
                PDES_WADDR: begin
                    if (bit_q == 4'h8) begin
                        addr_d = shift_q;
                        bit_d = 4'h9;
                        oe_d = 1'b1;
                        state_d = PDES_ACK;
                        rd_d = 1'b0;
                    end else begin
                        oe_d = 1'b0;
                    end
                end
                PDES_WDATA: begin
                    if (bit_q == 4'h8) begin
                        if (!strap_s2_q[1]) begin
                            req.we = 1'b1;
                            req.wdata = shift_q;
                            wrote_d = 1'b1;
                            addr_d = {addr_q[7:4], addr_q[3:0] + 4'h1};
                            oe_d = 1'b1;
                            bit_d = 4'h9;
                        end else begin
                            state_d = PDES_IDLE;
                        end
                    end else if (bit_q == 4'h9) begin
                        oe_d = 1'b0;
                        bit_d = 4'h0;
                    end
                end
                PDES_READ: begin
                    if (bit_q < 4'h8) begin
                        oe_d = ~rbyte_q[7];
                        rbyte_d = {rbyte_q[6:0], 1'b0};
                    end else if (bit_q == 4'h8) begin
                        // Release for the master's acknowledge
                        oe_d = 1'b0;
                    end else begin
                        // Master acked: next byte
                        bit_d = 4'h0;
                        oe_d = ~rdata[7];
                        rbyte_d = {rdata[6:0], 1'b0};
                        addr_d = addr_q + 8'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= PDES_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            addr_q <= 8'h00;
            prot_q <= 1'b0;
            rd_q <= 1'b0;
            wrote_q <= 1'b0;
            oe_q <= 1'b0;
            rbyte_q <= 8'h00;
            prog_q <= 24'h0;
        end else if (ce) begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            prot_q <= prot_d;
            rd_q <= rd_d;
            wrote_q <= wrote_d;
            oe_q <= oe_d;
            rbyte_q <= rbyte_d;
            prog_q <= prog_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign busy = (prog_q != 24'h0);
endmodule : pdes_slave

//--- core/pdes_store.sv
// Byte store with fixed content bytes and a protection byte.
// Assumes one request per cycle, read data one cycle later.
`timescale 1ns/1ps
module pdes_store
    import pdes_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter bit LARGE_ROW = 1'b0,
    parameter bit LARGE_COL = 1'b0
)(
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Access
    input pdes_mem_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] prot_q;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] fixed;
    logic is_fixed;

    // Fixed bytes override the array and ignore writes
    always_comb begin
        is_fixed = 1'b1;
        fixed = 8'h00;
        case (req.addr)
            8'h00: fixed = `PDES_B0_USED;
            8'h01: fixed = `PDES_B1_TOTAL;
            8'h02: fixed = `PDES_B2_TYPE;
            8'h03: fixed = LARGE_ROW ? `PDES_B3_ROW_LARGE : `PDES_B3_ROW_SMALL;
            8'h04: fixed = LARGE_COL ? `PDES_B4_COL_LARGE : `PDES_B4_COL_SMALL;
            8'h05: fixed = `PDES_B5_RANKS;
            8'h06: fixed = `PDES_B6_WIDTH_LO;
            8'h07: fixed = `PDES_B7_WIDTH_HI;
            8'h08: fixed = `PDES_B8_LEVELS;
            8'h0D: fixed = `PDES_B13_DEV_WIDTH;
            8'h0F: fixed = `PDES_B15_CCD;
            8'h11: fixed = `PDES_B17_BANKS;
            8'h16: fixed = `PDES_B22_ATTR;
            default: is_fixed = 1'b0;
        endcase
        if (req.prot) begin
            rdata_d = prot_q;
        end else if (is_fixed) begin
            rdata_d = fixed;
        end else begin
            rdata_d = mem_q[req.addr];
        end
    end

    // No reset on the array: nonvolatile contents
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata_q <= rdata_d;
            if (req.we && req.prot) begin
                prot_q <= req.wdata;
            end
            if (req.we && !req.prot && !is_fixed) begin
                mem_q[req.addr] <= req.wdata;
            end
        end
    end

    assign rdata = rdata_q;
endmodule : pdes_store
